// ===== verilog/desc_ctrl.sv
// Driver enable, auto spare, foldback, air and interlock control
`default_nettype none
// Overview of operation
// - A power request (turn_on_req_n low) turns on the driver stage modules.
// - The off command withdraws on-commands from every driver module unless the test jumper is set.
// - Enable high drives module lines to on level, low to off level.
// - Four shared outputs run thirteen main modules; spares get own outputs.
// - Three single modules follow the enable or are forced off by factory jumpers.
// - Manual spare runs only while the spare select switch is on.
// - Auto spare stays off while its enable switch is off.
// - Auto spare state is set/reset storage; indicator lights while on.
// - Drive below on-threshold sets the auto spare state.
// - Drive above off-threshold resets the auto spare state.
// - Drive inside the window resets the auto spare state.
// - Test jumper enables all modules except auto spare, transmitter off.
// - Missing module or cable lights interlock indicator and signals fault.
// - Near foldback point, caution indicator lights, power unchanged.
// - Further rise pulses power lower and flashes over-temp indicator.
// - Still rising, power lower held high and over-temp latched on.
// - Reduced air flow lights reduced indicator and amber air status.
// - Further reduced air flow signals air fault and red status; power stays on.
// - Latched over-temp stays until fault indication clear or the control clear bit is asserted.
module desc_ctrl #(
    parameter int FLASH_HALF = desc_pkg::FLASH_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        turn_on_req_n,
    input  wire logic        power_off_cmd,
    input  wire logic        spare_select_switch,
    input  wire logic        auto_spare_enable_switch,
    input  wire logic        test_mode_jumper,
    input  wire logic        module_select_jumper_a,
    input  wire logic        module_select_jumper_b,
    input  wire logic        module_select_jumper_c,
    input  wire logic        drive_below_on,
    input  wire logic        drive_above_off,
    input  wire logic        cable_chain_ok,
    input  wire logic        temp_caution_cmp,
    input  wire logic        temp_lower_cmp,
    input  wire logic        temp_rapid_cmp,
    input  wire logic        air_reduced_cmp,
    input  wire logic        air_fault_cmp,
    input  wire logic        fault_indication_clear,
    output logic [3:0]       main_group_on_n,
    output logic [2:0]       jumper_module_on_n,
    output logic             manual_spare_on_n,
    output logic             auto_spare_on_n,
    output logic             auto_spare_indicator,
    output logic             cable_interlock_indicator,
    output logic             cable_interlock_fault,
    output logic             temp_caution_indicator,
    output logic             over_temp_indicator,
    output logic             power_lower_req,
    output logic             airflow_reduced_indicator,
    output logic             air_status_amber,
    output logic             air_fault,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int NIN = 16;

    // Register map decode, shared by both channels
    function automatic logic [1:0] map_sel(input logic [31:0] a);
        logic [1:0] s;
        s = 2'h0;
        if (a[31:4] == 28'h000_0000) begin
            if (a[3:0] == desc_pkg::CTRL_ADDR)
                s = 2'h1;
            else if (a[3:0] == desc_pkg::STATUS_ADDR)
                s = 2'h2;
            else if (a[3:0] == desc_pkg::ID_ADDR)
                s = 2'h3;
        end
        return s;
    endfunction

    // Two-stage synchronisers
    logic [NIN-1:0] raw;
    logic [NIN-1:0] sync_a;
    logic [NIN-1:0] sync_b;
    assign raw = {fault_indication_clear, air_fault_cmp, air_reduced_cmp,
                  temp_rapid_cmp, temp_lower_cmp, temp_caution_cmp,
                  cable_chain_ok, drive_above_off, drive_below_on,
                  module_select_jumper_c, module_select_jumper_b,
                  module_select_jumper_a, test_mode_jumper,
                  auto_spare_enable_switch, spare_select_switch,
                  turn_on_req_n};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // Request inactive and cable chain intact, so no false fault
            sync_a <= 16'h0201;
            sync_b <= 16'h0201;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end

    wire logic       s_req_n   = sync_b[0];
    wire logic       s_spare   = sync_b[1];
    wire logic       s_auto_en = sync_b[2];
    wire logic       s_test    = sync_b[3];
    wire logic [2:0] s_jumper  = sync_b[6:4];
    wire logic       s_below   = sync_b[7];
    wire logic       s_above   = sync_b[8];
    wire logic       s_cable   = sync_b[9];
    wire logic       s_caution = sync_b[10];
    wire logic       s_lower   = sync_b[11];
    wire logic       s_rapid   = sync_b[12];
    wire logic       s_air_red = sync_b[13];
    wire logic       s_air_flt = sync_b[14];
    wire logic       s_clear   = sync_b[15];
    // Off command is from the same clock domain
    wire logic       on_request = ~s_req_n;

    // Power state
    logic power_on;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            power_on <= 1'b0;
        else if (power_off_cmd)
            power_on <= 1'b0;
        else if (on_request)
            power_on <= 1'b1;
    end

    logic [1:0] ctrl;
    wire logic  inhibit   = ctrl[desc_pkg::CTRL_INHIBIT_BIT];
    wire logic  drive_en  = power_on | s_test;
    wire logic  spare_en  = drive_en & s_spare;
    wire logic  auto_allow = power_on & s_auto_en & ~inhibit;

    // Auto spare set/reset state
    desc_pkg::desc_spare_t spare_st;
    desc_pkg::desc_spare_t next_spare_st;
    always_comb begin
        case (spare_st)
            desc_pkg::AS_OFF:
                next_spare_st = (auto_allow & s_below) ?
                    desc_pkg::AS_ON : desc_pkg::AS_OFF;
            desc_pkg::AS_ON:
                next_spare_st = (auto_allow & s_below & ~s_above) ?
                    desc_pkg::AS_ON : desc_pkg::AS_OFF;
            default:
                next_spare_st = desc_pkg::AS_OFF;
        endcase
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            spare_st <= desc_pkg::AS_OFF;
        else
            spare_st <= next_spare_st;
    end
    wire logic auto_on = (spare_st == desc_pkg::AS_ON);

    // Module drive outputs, low means on
    logic [3:0] next_main_n;
    logic [2:0] next_jmp_n;
    assign next_main_n = {desc_pkg::MAIN_GROUPS{~drive_en}};
    assign next_jmp_n  = ~({desc_pkg::JUMPER_MODS{drive_en}} & s_jumper);

    // Temperature foldback
    logic [desc_pkg::FLASH_W-1:0] flash_cnt;
    logic                         blink;
    logic                         temp_latch;
    wire logic gradual = s_lower & ~s_rapid;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flash_cnt <= 23'h00_0000;
            blink     <= 1'b0;
        end else if (!s_lower) begin
            flash_cnt <= 23'h00_0000;
            blink     <= 1'b0;
        end else if (flash_cnt == desc_pkg::FLASH_W'(FLASH_HALF - 1)) begin
            flash_cnt <= 23'h00_0000;
            blink     <= ~blink;
        end else begin
            flash_cnt <= flash_cnt + 23'h00_0001;
        end
    end
    // Set wins over clear
    wire logic soft_clear = ctrl[desc_pkg::CTRL_CLEAR_BIT];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            temp_latch <= 1'b0;
        else if (s_rapid)
            temp_latch <= 1'b1;
        else if (s_clear | soft_clear)
            temp_latch <= 1'b0;
    end

    // Registered outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            main_group_on_n           <= 4'hF;
            jumper_module_on_n        <= 3'h7;
            manual_spare_on_n         <= 1'b1;
            auto_spare_on_n           <= 1'b1;
            auto_spare_indicator      <= 1'b0;
            cable_interlock_indicator <= 1'b0;
            cable_interlock_fault     <= 1'b0;
            temp_caution_indicator    <= 1'b0;
            over_temp_indicator       <= 1'b0;
            power_lower_req           <= 1'b0;
            airflow_reduced_indicator <= 1'b0;
            air_status_amber          <= 1'b0;
            air_fault                 <= 1'b0;
        end else begin
            main_group_on_n           <= next_main_n;
            jumper_module_on_n        <= next_jmp_n;
            manual_spare_on_n         <= ~spare_en;
            auto_spare_on_n           <= ~auto_on;
            auto_spare_indicator      <= auto_on;
            cable_interlock_indicator <= ~s_cable;
            cable_interlock_fault     <= ~s_cable;
            temp_caution_indicator    <= s_caution;
            over_temp_indicator       <= temp_latch | (gradual & blink);
            power_lower_req           <= s_rapid | (gradual & blink);
            airflow_reduced_indicator <= s_air_red;
            air_status_amber          <= s_air_red & ~s_air_flt;
            air_fault                 <= s_air_flt;
        end
    end

    // AXI4-Lite slave
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire logic do_write = aw_held & w_held & ~s_axi_bvalid;
    wire logic [1:0] wsel = map_sel(aw_addr);
    wire logic [1:0] rsel = map_sel(s_axi_araddr);
    wire logic ctrl_wr = do_write & (wsel == 2'h1) & w_strb[0];

    logic [desc_pkg::ST_WIDTH-1:0] status;
    assign status = {s_test, air_fault, air_status_amber, temp_latch,
                     gradual, temp_caution_indicator,
                     cable_interlock_fault, auto_on, power_on};
    logic [31:0] rd_word;
    assign rd_word = (rsel == 2'h1) ? {30'h0000_0000, ctrl} :
                     (rsel == 2'h2) ? {23'h00_0000, status} :
                     (rsel == 2'h3) ? desc_pkg::ID_VALUE : 32'h0000_0000;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= desc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wsel == 2'h0) ? desc_pkg::RESP_SLVERR :
                                             desc_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Clear bit self-clears one cycle after it is written
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            ctrl <= desc_pkg::CTRL_RESET;
        else if (ctrl_wr)
            ctrl <= w_data[1:0];
        else
            ctrl[desc_pkg::CTRL_CLEAR_BIT] <= 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= desc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (rsel == 2'h0) ? desc_pkg::RESP_SLVERR :
                                             desc_pkg::RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_off_withdraws: assert property (
        power_off_cmd && !s_test |=> ##1 (main_group_on_n == 4'hF)
            ##1 auto_spare_on_n)
        else $error("modules still on after off command");
    a_on_request: assert property (
        !s_req_n && !power_off_cmd |=> ##1 main_group_on_n == 4'h0)
        else $error("modules not on after power request");
    a_auto_disabled: assert property (
        !s_auto_en |=> ##1 auto_spare_on_n)
        else $error("auto spare on while disabled");
    a_spare_gate: assert property (
        !s_spare |=> manual_spare_on_n)
        else $error("manual spare on with switch off");
    a_spare_set: assert property (
        auto_allow && s_below |=> ##1 !auto_spare_on_n)
        else $error("auto spare not set below threshold");
    a_spare_reset: assert property (
        s_above || !s_below |=> ##1 auto_spare_on_n)
        else $error("auto spare not reset");
    a_test_mode: assert property (
        s_test && !power_on |=> (main_group_on_n == 4'h0
            && manual_spare_on_n == !$past(s_spare)) ##1 auto_spare_on_n)
        else $error("test mode drive wrong");
    a_cable_fault: assert property (
        !s_cable |=> cable_interlock_fault && cable_interlock_indicator)
        else $error("cable interlock not flagged");
    a_rapid_latch: assert property (
        s_rapid |=> power_lower_req ##1 over_temp_indicator)
        else $error("rapid foldback not latched");
    a_latch_holds: assert property (
        temp_latch && !s_clear && !soft_clear |=> temp_latch)
        else $error("over temp latch dropped");
    a_air_red: assert property (
        s_air_flt |=> air_fault && !air_status_amber)
        else $error("air fault not red");
    a_write_resp: assert property (
        do_write |=> s_axi_bvalid)
        else $error("write response missing");

    c_auto_spare: cover property (auto_on ##1 !auto_on);
    c_gradual: cover property (gradual && blink);
    c_clear: cover property (temp_latch ##1 !temp_latch);
    c_write: cover property (ctrl_wr);
endmodule
`default_nettype wire

// ===== verilog/desc_pkg.sv
// Constants for the driver enable and auto spare controller
`default_nettype none
package desc_pkg;
    // Bus register byte offsets
    localparam logic [3:0] CTRL_ADDR   = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] ID_ADDR     = 4'h8;
    // Control register fields
    localparam int CTRL_CLEAR_BIT   = 0;
    localparam int CTRL_INHIBIT_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Status register fields
    localparam int ST_POWER_BIT    = 0;
    localparam int ST_SPARE_BIT    = 1;
    localparam int ST_CABLE_BIT    = 2;
    localparam int ST_CAUTION_BIT  = 3;
    localparam int ST_GRADUAL_BIT  = 4;
    localparam int ST_LATCH_BIT    = 5;
    localparam int ST_AMBER_BIT    = 6;
    localparam int ST_RED_BIT      = 7;
    localparam int ST_TEST_BIT     = 8;
    localparam int ST_WIDTH        = 9;
    // Identity word, arbitrary value
    localparam logic [31:0] ID_VALUE = 32'h0D0E_0001;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Module groups
    localparam int MAIN_GROUPS  = 4;
    localparam int JUMPER_MODS  = 3;
    // Flash half period, and clock rate
    localparam int FLASH_HALF_MS = 250;
    localparam int CLK_HZ        = 25_000_000;
    localparam int FLASH_CYCLES  = FLASH_HALF_MS * (CLK_HZ / 1000);
    localparam int FLASH_W       = 23;
    // Auto spare state codes
    typedef enum logic [1:0] {
        AS_OFF = 2'b01,
        AS_ON  = 2'b10
    } desc_spare_t;
endpackage
`default_nettype wire

// ===== tb/desc_drv_model.sv
// Behavioural model of the driver modules and the drive sensing
`default_nettype none
module desc_drv_model (
    input  wire logic       removed,
    input  wire logic [1:0] level,
    output logic            cable_chain_ok,
    output logic            drive_below_on,
    output logic            drive_above_off
);
    timeunit 1ns;
    timeprecision 1ns;
    // Chain opens as soon as any module is pulled
    assign cable_chain_ok  = !removed;
    // Level 0 weak drive, 1 inside the window, 2 strong drive
    assign drive_below_on  = (level == 2'h0);
    assign drive_above_off = (level == 2'h2);
endmodule
`default_nettype wire

// ===== tb/test_driver_enable_auto_spare_ctrl.sv
// Self-checking bench for the driver enable and auto spare controller
`default_nettype none
module test_driver_enable_auto_spare_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic turn_on_req_n, power_off_cmd, spare_select_switch;
    logic auto_spare_enable_switch, test_mode_jumper, removed;
    logic module_select_jumper_a, module_select_jumper_b;
    logic module_select_jumper_c, fault_indication_clear;
    logic temp_caution_cmp, temp_lower_cmp, temp_rapid_cmp;
    logic air_reduced_cmp, air_fault_cmp;
    logic [1:0] level;
    wire logic drive_below_on, drive_above_off, cable_chain_ok;
    wire logic [3:0] main_group_on_n;
    wire logic [2:0] jumper_module_on_n;
    wire logic manual_spare_on_n, auto_spare_on_n, auto_spare_indicator;
    wire logic cable_interlock_indicator, cable_interlock_fault;
    wire logic temp_caution_indicator, over_temp_indicator;
    wire logic power_lower_req, airflow_reduced_indicator;
    wire logic air_status_amber, air_fault;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [17:0] pins;
    int mismatches = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h0000_0E46;
    logic pwr, inh, latch;
    logic [17:0] pin_q[$];
    logic [33:0] bus_q[$];
    assign pins = {main_group_on_n, jumper_module_on_n, manual_spare_on_n,
        auto_spare_on_n, auto_spare_indicator, cable_interlock_indicator,
        cable_interlock_fault, temp_caution_indicator, over_temp_indicator,
        power_lower_req, airflow_reduced_indicator, air_status_amber,
        air_fault};
    desc_drv_model partner (.removed, .level, .cable_chain_ok,
        .drive_below_on, .drive_above_off);
    desc_ctrl #(.FLASH_HALF(4)) dut (.core_clk, .rst, .turn_on_req_n,
        .power_off_cmd, .spare_select_switch, .auto_spare_enable_switch,
        .test_mode_jumper, .module_select_jumper_a, .module_select_jumper_b,
        .module_select_jumper_c, .drive_below_on, .drive_above_off,
        .cable_chain_ok, .temp_caution_cmp, .temp_lower_cmp, .temp_rapid_cmp,
        .air_reduced_cmp, .air_fault_cmp, .fault_indication_clear,
        .main_group_on_n, .jumper_module_on_n, .manual_spare_on_n,
        .auto_spare_on_n, .auto_spare_indicator, .cable_interlock_indicator,
        .cable_interlock_fault, .temp_caution_indicator, .over_temp_indicator,
        .power_lower_req, .airflow_reduced_indicator, .air_status_amber,
        .air_fault, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    always #20 core_clk = ~core_clk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [17:0] exp_pins();
        logic en;
        logic as;
        en = pwr | test_mode_jumper;
        as = pwr & auto_spare_enable_switch & ~inh & (level == 2'h0);
        return {{4{~en}}, ~({3{en}} & {module_select_jumper_c,
            module_select_jumper_b, module_select_jumper_a}),
            ~(en & spare_select_switch), ~as, as, removed, removed,
            temp_caution_cmp, latch, temp_rapid_cmp, air_reduced_cmp,
            air_reduced_cmp & ~air_fault_cmp, air_fault_cmp};
    endfunction
    task automatic cmp_pins(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t pins got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t bus got %h exp %h", $time, got, exp);
        end
    endtask
    always @(negedge core_clk) begin
        if (pin_q.size() > 0)
            cmp_pins(pins, pin_q.pop_front());
        if (s_axi_bvalid && s_axi_bready && bus_q.size() > 0)
            cmp_bus({32'h0000_0000, s_axi_bresp}, bus_q.pop_front());
        if (s_axi_rvalid && s_axi_rready && bus_q.size() > 0)
            cmp_bus({s_axi_rdata, s_axi_rresp}, bus_q.pop_front());
    end
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        logic aw_t, w_t, b_t;
        bus_q.push_back({32'h0000_0000, e});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge core_clk);
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t = s_axi_wvalid & s_axi_wready;
            b_t = s_axi_bready & s_axi_bvalid;
            @(posedge core_clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (b_t) s_axi_bready <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        logic ar_t, r_t;
        bus_q.push_back({d, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge core_clk);
            ar_t = s_axi_arvalid & s_axi_arready;
            r_t = s_axi_rready & s_axi_rvalid;
            @(posedge core_clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (r_t) s_axi_rready <= 1'b0;
        end while (s_axi_arvalid || s_axi_rready);
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        mismatches++;
        stop_test();
    end
    initial begin
        logic [31:0] r;
        logic [17:0] p;
        int ot, pl;
        {power_off_cmd, spare_select_switch, auto_spare_enable_switch} = '0;
        {test_mode_jumper, removed, fault_indication_clear} = '0;
        {module_select_jumper_a, module_select_jumper_b} = '0;
        module_select_jumper_c = 1'b0;
        {temp_caution_cmp, temp_lower_cmp, temp_rapid_cmp} = '0;
        {air_reduced_cmp, air_fault_cmp} = '0;
        turn_on_req_n = 1'b1;
        level = 2'h1;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {pwr, inh, latch} = '0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        pin_q.push_back(exp_pins());
        rd(desc_pkg::CTRL_ADDR, 32'h0000_0000, desc_pkg::RESP_OKAY);
        rd(desc_pkg::ID_ADDR, desc_pkg::ID_VALUE, desc_pkg::RESP_OKAY);
        rd(32'h0000_0010, 32'h0000_0000, desc_pkg::RESP_SLVERR);
        wr(32'h0000_0010, 32'h0000_0003, desc_pkg::RESP_SLVERR);
        for (int i = 0; i < 24; i++) begin
            if (i == 12) begin
                turn_on_req_n <= 1'b0;
                pwr = 1'b1;
            end
            r = xs();
            spare_select_switch <= r[0];
            auto_spare_enable_switch <= r[1] | r[14];
            test_mode_jumper <= r[2] & r[3];
            {module_select_jumper_c, module_select_jumper_b,
                module_select_jumper_a} <= r[6:4];
            level <= (r[8:7] == 2'h3) ? 2'h0 : r[8:7];
            removed <= r[9] & r[10];
            temp_caution_cmp <= r[11];
            air_reduced_cmp <= r[12];
            air_fault_cmp <= r[12] & r[13];
            settle();
            pin_q.push_back(exp_pins());
            p = exp_pins();
        end
        rd(desc_pkg::STATUS_ADDR, {23'h0, test_mode_jumper, air_fault_cmp,
            air_reduced_cmp & ~air_fault_cmp, latch, 1'b0, temp_caution_cmp,
            removed, p[8], pwr}, desc_pkg::RESP_OKAY);
        test_mode_jumper <= 1'b0;
        auto_spare_enable_switch <= 1'b1;
        level <= 2'h0;
        wr(desc_pkg::CTRL_ADDR, 32'h0000_0002, desc_pkg::RESP_OKAY);
        inh = 1'b1;
        settle();
        pin_q.push_back(exp_pins());
        rd(desc_pkg::CTRL_ADDR, 32'h0000_0002, desc_pkg::RESP_OKAY);
        wr(desc_pkg::CTRL_ADDR, 32'h0000_0000, desc_pkg::RESP_OKAY);
        inh = 1'b0;
        settle();
        pin_q.push_back(exp_pins());
        power_off_cmd <= 1'b1;
        turn_on_req_n <= 1'b1;
        pwr = 1'b0;
        settle();
        pin_q.push_back(exp_pins());
        power_off_cmd <= 1'b0;
        {temp_rapid_cmp, temp_lower_cmp, temp_caution_cmp} <= 3'h7;
        latch = 1'b1;
        settle();
        pin_q.push_back(exp_pins());
        {temp_rapid_cmp, temp_lower_cmp} <= 2'h0;
        settle();
        pin_q.push_back(exp_pins());
        fault_indication_clear <= 1'b1;
        latch = 1'b0;
        settle();
        fault_indication_clear <= 1'b0;
        settle();
        pin_q.push_back(exp_pins());
        temp_rapid_cmp <= 1'b1;
        settle();
        temp_rapid_cmp <= 1'b0;
        settle();
        wr(desc_pkg::CTRL_ADDR, 32'h0000_0001, desc_pkg::RESP_OKAY);
        latch = 1'b0;
        settle();
        pin_q.push_back(exp_pins());
        temp_lower_cmp <= 1'b1;
        settle();
        ot = 0;
        pl = 0;
        @(negedge core_clk);
        p = pins;
        repeat (40) begin
            @(negedge core_clk);
            ot += (p[4] != over_temp_indicator);
            pl += (p[3] != power_lower_req);
            p = pins;
        end
        p = exp_pins();
        cmp_pins({pins[17:5], ot > 2, pl > 2, pins[2:0]},
                 {p[17:5], 2'h3, p[2:0]});
        stop_test();
    end
endmodule
`default_nettype wire
